// File: src/perf_qual_pkg.sv
// Purpose: shared constants and types for the load latency and off-core qualifier
// Assumes: one core clock; register port addresses are 12 bits wide
// Notes: data-source codes are the values written into the precise_sample_record
package perf_qual_pkg;

   // register port
   localparam int MSR_ADDR_W = 12;
   localparam int REG_W = 16;
   localparam logic [MSR_ADDR_W-1:0] OFFCORE_SELECT_ADDR = 12'h1A6;
   localparam logic [MSR_ADDR_W-1:0] LATENCY_THRESHOLD_ADDR = 12'h0C0;
   localparam logic [REG_W-1:0] OFFCORE_SELECT_RESET = 16'h0000;
   localparam logic [REG_W-1:0] LATENCY_THRESHOLD_RESET = 16'h0003;
   localparam logic [REG_W-1:0] OFFCORE_WRITABLE_MASK = 16'hF7FF;

   // off-core select layout
   localparam int REQ_LSB = 0;
   localparam int REQ_MSB = 7;
   localparam int RESP_LSB = 8;
   localparam int RESP_MSB = 15;
   localparam int SEL_DEMAND_DATA_READ = 0;
   localparam int SEL_DEMAND_OWNERSHIP_READ = 1;
   localparam int SEL_DEMAND_CODE_READ = 2;
   localparam int SEL_WRITEBACK = 3;
   localparam int SEL_PREFETCH_DATA_READ = 4;
   localparam int SEL_PREFETCH_OWNERSHIP_READ = 5;
   localparam int SEL_PREFETCH_CODE_READ = 6;
   localparam int SEL_MISC = 7;
   localparam int RESP_L3_NO_SNOOP = 8;
   localparam int RESP_CLEAN_SNOOP_HIT = 9;
   localparam int RESP_DIRTY_SNOOP_HIT = 10;
   localparam int RESP_RESERVED = 11;
   localparam int RESP_CROSS_PACKAGE_FORWARD = 12;
   localparam int RESP_REMOTE_MEMORY = 13;
   localparam int RESP_LOCAL_MEMORY = 14;
   localparam int RESP_IO_HUB = 15;

   // latency measurement
   localparam int LAT_W = 16;
   localparam logic [LAT_W-1:0] MIN_DETECT_LATENCY = 16'h0004;
   localparam logic [LAT_W-1:0] LATENCY_START = 16'h0001;
   localparam logic [LAT_W-1:0] LATENCY_STEP = 16'h0001;
   localparam logic [LAT_W-1:0] LATENCY_MAX = 16'hFFFF;

   // data-source codes
   localparam logic [7:0] CODE_UNKNOWN_MISS = 8'h00;
   localparam logic [7:0] CODE_L1_HIT = 8'h01;
   localparam logic [7:0] CODE_PENDING_HIT = 8'h02;
   localparam logic [7:0] CODE_L2_HIT = 8'h03;
   localparam logic [7:0] CODE_L3_NO_SNOOP = 8'h04;
   localparam logic [7:0] CODE_L3_CLEAN_SNOOP = 8'h05;
   localparam logic [7:0] CODE_L3_DIRTY_SNOOP = 8'h06;
   localparam logic [7:0] CODE_LLC_DIRTY_SNOOP = 8'h07;
   localparam logic [7:0] CODE_CROSS_PACKAGE_FWD = 8'h08;
   localparam logic [7:0] CODE_LOCAL_MEM_SHARED = 8'h0A;
   localparam logic [7:0] CODE_REMOTE_MEM_SHARED = 8'h0B;
   localparam logic [7:0] CODE_LOCAL_MEM_EXCL = 8'h0C;
   localparam logic [7:0] CODE_REMOTE_MEM_EXCL = 8'h0D;
   localparam logic [7:0] CODE_IO = 8'h0E;
   localparam logic [7:0] CODE_UNCACHED = 8'h0F;

   typedef enum logic [1:0] {SNOOP_NONE, SNOOP_CLEAN, SNOOP_DIRTY} snoop_t;

endpackage : perf_qual_pkg

// File: src/source_encoder.sv
// Purpose: turns the load pipeline's completion descriptor into a data-source code
// Assumes: descriptor bits are valid in the cycle of global observation
// Notes: purely combinational; the caller registers the code
`timescale 1ns/1ps
module source_encoder
   import perf_qual_pkg::*;
#(
   parameter bit LLC_DIRTY_CODE_EN = 1'b0
)
(
   input wire logic l1_hit,
   input wire logic pending_hit,
   input wire logic l2_hit,
   input wire logic l3_hit,
   input wire snoop_t snoop,
   input wire logic miss_fwd,
   input wire logic miss_mem,
   input wire logic local_home,
   input wire logic exclusive,
   input wire logic io_req,
   input wire logic uncached,
   output logic [7:0] code
);

   logic [7:0] dirty_code;
   logic [7:0] hit_code;
   logic [7:0] local_mem_code;
   logic [7:0] remote_mem_code;
   logic [7:0] mem_code;
   logic [7:0] miss_code;

   // the alternate dirty-snoop code exists only on some models, reserved otherwise
   assign dirty_code = LLC_DIRTY_CODE_EN ? CODE_LLC_DIRTY_SNOOP : CODE_L3_DIRTY_SNOOP;
   assign hit_code = (snoop == SNOOP_NONE) ? CODE_L3_NO_SNOOP :
                     (snoop == SNOOP_CLEAN) ? CODE_L3_CLEAN_SNOOP : dirty_code;
   assign local_mem_code = exclusive ? CODE_LOCAL_MEM_EXCL : CODE_LOCAL_MEM_SHARED;
   assign remote_mem_code = exclusive ? CODE_REMOTE_MEM_EXCL : CODE_REMOTE_MEM_SHARED;
   assign mem_code = local_home ? local_mem_code : remote_mem_code;
   // a remotely homed forward has no code of its own and falls back to the memory code if miss_mem is set, else to unknown
   assign miss_code = (miss_fwd && local_home) ? CODE_CROSS_PACKAGE_FWD :
                      miss_mem ? mem_code : CODE_UNKNOWN_MISS;
   // uncached beats io beats every cache level
   assign code = uncached ? CODE_UNCACHED :
                 io_req ? CODE_IO :
                 l1_hit ? CODE_L1_HIT :
                 pending_hit ? CODE_PENDING_HIT :
                 l2_hit ? CODE_L2_HIT :
                 l3_hit ? hit_code : miss_code;

endmodule : source_encoder

// File: src/load_latency_offcore_qualifier.sv
// Purpose: load-latency filter with data-source record, and off-core response qualifier
// Assumes: all inputs come from core-clock logic; register port is the core's MSR port
// Notes: one tagged load is tracked at a time; a dispatch while busy is a re-dispatch
`timescale 1ns/1ps
module load_latency_offcore_qualifier
   import perf_qual_pkg::*;
#(
   parameter bit LLC_DIRTY_CODE_EN = 1'b0
)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [MSR_ADDR_W-1:0] MSR_ADDR,
   input wire logic MSR_WR,
   input wire logic MSR_RD,
   input wire logic [REG_W-1:0] MSR_WDATA,
   output logic [REG_W-1:0] MSR_RDATA,
   output logic MSR_RVALID,
   input wire logic LD_DISPATCH,
   input wire logic LD_GO,
   input wire logic LD_L1_HIT,
   input wire logic LD_PENDING,
   input wire logic LD_L2_HIT,
   input wire logic LD_L3_HIT,
   input wire snoop_t LD_SNOOP,
   input wire logic LD_MISS_FWD,
   input wire logic LD_MISS_MEM,
   input wire logic LD_LOCAL_HOME,
   input wire logic LD_EXCLUSIVE,
   input wire logic LD_IO,
   input wire logic LD_UNCACHED,
   output logic LAT_VALID,
   output logic [LAT_W-1:0] LAT_VALUE,
   output logic [7:0] LAT_SOURCE,
   input wire logic OC_VALID,
   input wire logic [7:0] OC_REQ,
   input wire logic [7:0] OC_RESP,
   output logic OC_COUNT
);

   logic [REG_W-1:0] offcore_response_select;
   logic [REG_W-1:0] load_latency_threshold;
   logic busy;
   logic [LAT_W-1:0] lat_cnt;
   logic [7:0] src_code;
   logic [LAT_W-1:0] measured;
   logic [LAT_W-1:0] next_lat_cnt;
   logic above;
   logic capture;
   logic start;
   logic wr_offcore;
   logic wr_threshold;
   logic [REG_W-1:0] rd_mux;
   logic [7:0] req_sel;
   logic [7:0] resp_sel;
   logic req_match;
   logic resp_match;

   // register port decode
   assign wr_offcore = MSR_WR && (MSR_ADDR == OFFCORE_SELECT_ADDR);
   assign wr_threshold = MSR_WR && (MSR_ADDR == LATENCY_THRESHOLD_ADDR);
   assign rd_mux = (MSR_ADDR == OFFCORE_SELECT_ADDR) ? offcore_response_select :
                   (MSR_ADDR == LATENCY_THRESHOLD_ADDR) ? load_latency_threshold : '0;

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         offcore_response_select <= OFFCORE_SELECT_RESET;
         load_latency_threshold <= LATENCY_THRESHOLD_RESET;
      end
      else
      begin
         // the reserved response bit never stores, so it always reads zero
         if (wr_offcore)
            offcore_response_select <= MSR_WDATA & OFFCORE_WRITABLE_MASK;
         // values below 3 are software's fault; stored as written
         if (wr_threshold)
            load_latency_threshold <= MSR_WDATA;
      end
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         MSR_RDATA <= '0;
         MSR_RVALID <= 1'b0;
      end
      else
      begin
         MSR_RVALID <= MSR_RD;
         if (MSR_RD)
            MSR_RDATA <= rd_mux;
      end
   end

   // latency tracking: the first dispatch starts the count, re-dispatches do not restart it
   assign start = LD_DISPATCH && !busy;
   assign next_lat_cnt = (lat_cnt == LATENCY_MAX) ? lat_cnt : lat_cnt + LATENCY_STEP;
   assign measured = (lat_cnt < MIN_DETECT_LATENCY) ? MIN_DETECT_LATENCY : lat_cnt;
   assign above = measured > load_latency_threshold;
   assign capture = LD_GO && busy && above;

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         busy <= 1'b0;
         lat_cnt <= '0;
      end
      else if (busy && LD_GO)
         busy <= 1'b0;
      else if (start)
      begin
         busy <= 1'b1;
         lat_cnt <= LATENCY_START;
      end
      else if (busy)
         lat_cnt <= next_lat_cnt;
   end

   source_encoder #(
      .LLC_DIRTY_CODE_EN(LLC_DIRTY_CODE_EN)
   ) u_source_encoder (
      .l1_hit(LD_L1_HIT),
      .pending_hit(LD_PENDING),
      .l2_hit(LD_L2_HIT),
      .l3_hit(LD_L3_HIT),
      .snoop(LD_SNOOP),
      .miss_fwd(LD_MISS_FWD),
      .miss_mem(LD_MISS_MEM),
      .local_home(LD_LOCAL_HOME),
      .exclusive(LD_EXCLUSIVE),
      .io_req(LD_IO),
      .uncached(LD_UNCACHED),
      .code(src_code)
   );

   // record holds the last qualifying load until the next one replaces it
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         LAT_VALID <= 1'b0;
         LAT_VALUE <= '0;
         LAT_SOURCE <= CODE_UNKNOWN_MISS;
      end
      else
      begin
         LAT_VALID <= capture;
         if (capture)
         begin
            LAT_VALUE <= measured;
            LAT_SOURCE <= src_code;
         end
      end
   end

   // off-core qualification; bit order of both vectors follows the select register
   assign req_sel = offcore_response_select[REQ_MSB:REQ_LSB];
   assign resp_sel = offcore_response_select[RESP_MSB:RESP_LSB];
   assign req_match = |(OC_REQ & req_sel);
   assign resp_match = |(OC_RESP & resp_sel);

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         OC_COUNT <= 1'b0;
      else
         OC_COUNT <= OC_VALID && req_match && resp_match;
   end

   // checks
   logic cached_path;
   logic miss_path;
   assign cached_path = !LD_UNCACHED && !LD_IO && !LD_L1_HIT && !LD_PENDING && !LD_L2_HIT;
   assign miss_path = cached_path && !LD_L3_HIT;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   property p_unknown; capture && miss_path && !(LD_MISS_FWD && LD_LOCAL_HOME) && !LD_MISS_MEM
      |=> LAT_SOURCE == CODE_UNKNOWN_MISS; endproperty
   a_unknown: assert property (p_unknown) else $error("unknown miss code wrong");
   property p_l1; capture && LD_L1_HIT && !LD_IO && !LD_UNCACHED |=> LAT_SOURCE == CODE_L1_HIT; endproperty
   a_l1: assert property (p_l1) else $error("l1 hit code wrong");
   property p_pending; capture && LD_PENDING && !LD_L1_HIT && !LD_IO && !LD_UNCACHED
      |=> LAT_SOURCE == CODE_PENDING_HIT; endproperty
   a_pending: assert property (p_pending) else $error("pending hit code wrong");
   property p_l2; capture && LD_L2_HIT && !LD_PENDING && !LD_L1_HIT && !LD_IO && !LD_UNCACHED
      |=> LAT_SOURCE == CODE_L2_HIT; endproperty
   a_l2: assert property (p_l2) else $error("l2 hit code wrong");
   property p_l3_none; capture && cached_path && LD_L3_HIT && LD_SNOOP == SNOOP_NONE
      |=> LAT_SOURCE == CODE_L3_NO_SNOOP; endproperty
   a_l3_none: assert property (p_l3_none) else $error("l3 no-snoop code wrong");
   property p_l3_clean; capture && cached_path && LD_L3_HIT && LD_SNOOP == SNOOP_CLEAN
      |=> LAT_SOURCE == CODE_L3_CLEAN_SNOOP; endproperty
   a_l3_clean: assert property (p_l3_clean) else $error("l3 clean snoop code wrong");
   property p_l3_dirty; capture && cached_path && LD_L3_HIT && LD_SNOOP == SNOOP_DIRTY
      |=> LAT_SOURCE == (LLC_DIRTY_CODE_EN ? CODE_LLC_DIRTY_SNOOP : CODE_L3_DIRTY_SNOOP); endproperty
   a_l3_dirty: assert property (p_l3_dirty) else $error("l3 dirty snoop code wrong");
   property p_fwd; capture && miss_path && LD_MISS_FWD && LD_LOCAL_HOME
      |=> LAT_SOURCE == CODE_CROSS_PACKAGE_FWD; endproperty
   a_fwd: assert property (p_fwd) else $error("forward code wrong");
   property p_no_remote_fwd; capture && !LD_LOCAL_HOME |=> LAT_SOURCE != CODE_CROSS_PACKAGE_FWD; endproperty
   a_no_remote_fwd: assert property (p_no_remote_fwd) else $error("remote home gave forward code");
   property p_local_mem; capture && miss_path && !LD_MISS_FWD && LD_MISS_MEM && LD_LOCAL_HOME
      |=> LAT_SOURCE == ($past(LD_EXCLUSIVE) ? CODE_LOCAL_MEM_EXCL : CODE_LOCAL_MEM_SHARED); endproperty
   a_local_mem: assert property (p_local_mem) else $error("local memory code wrong");
   property p_remote_mem; capture && miss_path && LD_MISS_MEM && !LD_LOCAL_HOME
      |=> LAT_SOURCE == ($past(LD_EXCLUSIVE) ? CODE_REMOTE_MEM_EXCL : CODE_REMOTE_MEM_SHARED); endproperty
   a_remote_mem: assert property (p_remote_mem) else $error("remote memory code wrong");
   property p_io; capture && LD_IO && !LD_UNCACHED |=> LAT_SOURCE == CODE_IO; endproperty
   a_io: assert property (p_io) else $error("io code wrong");
   property p_uc; capture && LD_UNCACHED |=> LAT_SOURCE == CODE_UNCACHED; endproperty
   a_uc: assert property (p_uc) else $error("uncached code wrong");
   property p_above; LAT_VALID |-> LAT_VALUE > $past(load_latency_threshold); endproperty
   a_above: assert property (p_above) else $error("record at or below threshold");
   property p_ignored; LD_GO && busy && !above |=> !LAT_VALID; endproperty
   a_ignored: assert property (p_ignored) else $error("load below threshold recorded");
   property p_six; (start && !LD_GO) ##1 (!LD_GO)[*5] ##1 (LD_GO && above) |=> LAT_VALUE == 16'h0006; endproperty
   a_six: assert property (p_six) else $error("latency not dispatch to observation");
   property p_min; LAT_VALID |-> LAT_VALUE >= MIN_DETECT_LATENCY; endproperty
   a_min: assert property (p_min) else $error("latency below detectable minimum");
   property p_count; OC_VALID && req_match && resp_match |=> OC_COUNT; endproperty
   a_count: assert property (p_count) else $error("qualifying transaction not counted");
   property p_no_count; OC_COUNT |-> $past(OC_VALID) && |($past(OC_REQ) & $past(req_sel))
      && |($past(OC_RESP) & $past(resp_sel)); endproperty
   a_no_count: assert property (p_no_count) else $error("count without both matches");
   property p_resv; MSR_RVALID && $past(MSR_ADDR) == OFFCORE_SELECT_ADDR |-> !MSR_RDATA[RESP_RESERVED];
   endproperty
   a_resv: assert property (p_resv) else $error("reserved select bit reads one");

   // register contents and read answer
   property p_req_store; wr_offcore
      |=> offcore_response_select[REQ_MSB:REQ_LSB] == $past(MSR_WDATA[REQ_MSB:REQ_LSB]); endproperty
   a_req_store: assert property (p_req_store) else $error("request select not stored");
   property p_hit_store; wr_offcore |=> offcore_response_select[RESP_DIRTY_SNOOP_HIT:RESP_L3_NO_SNOOP]
      == $past(MSR_WDATA[RESP_DIRTY_SNOOP_HIT:RESP_L3_NO_SNOOP]); endproperty
   a_hit_store: assert property (p_hit_store) else $error("hit response select not stored");
   property p_miss_store; wr_offcore |=> offcore_response_select[RESP_MSB:RESP_CROSS_PACKAGE_FORWARD]
      == $past(MSR_WDATA[RESP_MSB:RESP_CROSS_PACKAGE_FORWARD]); endproperty
   a_miss_store: assert property (p_miss_store) else $error("miss response select not stored");
   property p_thr_store; wr_threshold |=> load_latency_threshold == $past(MSR_WDATA); endproperty
   a_thr_store: assert property (p_thr_store) else $error("threshold not stored");
   property p_rvalid; MSR_RD |=> MSR_RVALID; endproperty
   a_rvalid: assert property (p_rvalid) else $error("read not answered next cycle");
   property p_thr_read; MSR_RD && MSR_ADDR == LATENCY_THRESHOLD_ADDR
      |=> MSR_RDATA == $past(load_latency_threshold); endproperty
   a_thr_read: assert property (p_thr_read) else $error("threshold read back wrong");

   // spot checks: writeback, prefetch data read and misc requests, io hub response
   property p_writeback; OC_VALID && OC_REQ[SEL_WRITEBACK] && offcore_response_select[SEL_WRITEBACK]
      && resp_match |=> OC_COUNT; endproperty
   a_writeback: assert property (p_writeback) else $error("writeback not counted");
   property p_pf_data; OC_VALID && OC_REQ[SEL_PREFETCH_DATA_READ]
      && offcore_response_select[SEL_PREFETCH_DATA_READ] && resp_match |=> OC_COUNT; endproperty
   a_pf_data: assert property (p_pf_data) else $error("prefetch data read not counted");
   property p_misc; OC_VALID && OC_REQ[SEL_MISC] && offcore_response_select[SEL_MISC]
      && resp_match |=> OC_COUNT; endproperty
   a_misc: assert property (p_misc) else $error("miscellaneous transaction not counted");
   property p_io_hub; OC_VALID && req_match && OC_RESP[RESP_IO_HUB - RESP_LSB]
      && offcore_response_select[RESP_IO_HUB] |=> OC_COUNT; endproperty
   a_io_hub: assert property (p_io_hub) else $error("io hub response not counted");

   // latency record and counter
   property p_hold; !capture |=> $stable(LAT_VALUE) && $stable(LAT_SOURCE); endproperty
   a_hold: assert property (p_hold) else $error("record changed without a qualifying load");
   property p_done; LD_GO && busy |=> !busy; endproperty
   a_done: assert property (p_done) else $error("tracking did not end at observation");
   property p_step; busy && !LD_GO && lat_cnt != LATENCY_MAX
      |=> lat_cnt == $past(lat_cnt) + LATENCY_STEP; endproperty
   a_step: assert property (p_step) else $error("latency count did not advance");

   c_record: cover property (capture ##1 LAT_VALID);
   c_ignored: cover property (LD_GO && busy && !above);
   c_offcore: cover property (OC_VALID ##1 OC_COUNT);
   c_write_read: cover property (wr_offcore ##2 MSR_RD ##1 MSR_RVALID);
   c_floor: cover property (capture && lat_cnt < MIN_DETECT_LATENCY);

endmodule : load_latency_offcore_qualifier

// File: verif/pipe_uncore_model.sv
// Purpose: load pipeline and uncore stand-in that drives tagged loads and off-core transactions
// Assumes: requests change 1 ns after the rising edge and hold until the next edge
// Notes: descriptor and type lines show the inverse of their last value outside their valid cycle
`timescale 1ns/1ps
module pipe_uncore_model
   import perf_qual_pkg::*;
(
   input wire logic clk,
   output logic dispatch,
   output logic go,
   output logic l1_hit,
   output logic pending,
   output logic l2_hit,
   output logic l3_hit,
   output snoop_t snoop,
   output logic miss_fwd,
   output logic miss_mem,
   output logic local_home,
   output logic exclusive,
   output logic io,
   output logic uncached,
   output logic oc_valid,
   output logic [7:0] oc_req,
   output logic [7:0] oc_resp
);
   // descriptor packing: uncached io l1 pending l2 l3 snoop[1:0] fwd mem local excl
   logic [11:0] desc;
   assign {uncached, io, l1_hit, pending, l2_hit, l3_hit} = desc[11:6];
   assign snoop = snoop_t'(desc[5:4]);
   assign {miss_fwd, miss_mem, local_home, exclusive} = desc[3:0];
   initial
   begin
      dispatch = 1'b0;
      go = 1'b0;
      desc = 12'h0FFF;
      oc_valid = 1'b0;
      oc_req = 8'h00;
      oc_resp = 8'h00;
   end
   // dispatch at edge e0, observation at edge e0+lat; returns 1 ns after that edge
   task automatic issue_load(input int lat, input logic [11:0] d);
      @(posedge clk);
      #1 dispatch = 1'b1;
      @(posedge clk);
      #1 dispatch = 1'b0;
      repeat (lat - 1) @(posedge clk);
      #1 go = 1'b1;
      desc = d;
      @(posedge clk);
      #1 go = 1'b0;
      desc = ~d;
   endtask : issue_load
   task automatic send_oc(input logic [7:0] rq, input logic [7:0] rs);
      @(posedge clk);
      #1 oc_valid = 1'b1;
      oc_req = rq;
      oc_resp = rs;
      @(posedge clk);
      #1 oc_valid = 1'b0;
      oc_req = ~rq;
      oc_resp = ~rs;
   endtask : send_oc
endmodule : pipe_uncore_model

// File: verif/tb_load_latency_offcore_qualifier.sv
// Purpose: self-checking bench for the load latency filter and off-core qualifier
// Assumes: default build, so a dirty cross-core snoop reports 06H
// Notes: register port driven here; loads and off-core traffic come from the partner model
`timescale 1ns/1ps
module tb_load_latency_offcore_qualifier
   import perf_qual_pkg::*;
;
   logic clk, rst, msr_wr, msr_rd, msr_rvalid, ld_dispatch, ld_go, l1, pnd, l2, l3;
   logic fwd, mem, loc, excl, io, unc, lat_valid, oc_valid, oc_count;
   logic [MSR_ADDR_W-1:0] msr_addr;
   logic [REG_W-1:0] msr_wdata, msr_rdata;
   logic [LAT_W-1:0] lat_value;
   logic [7:0] lat_source, oc_req, oc_resp;
   snoop_t snp;
   int fails = 0;
   int n_compared = 0;
   load_latency_offcore_qualifier dut_u (.CLK(clk), .RST(rst), .MSR_ADDR(msr_addr), .MSR_WR(msr_wr),
      .MSR_RD(msr_rd), .MSR_WDATA(msr_wdata), .MSR_RDATA(msr_rdata), .MSR_RVALID(msr_rvalid),
      .LD_DISPATCH(ld_dispatch), .LD_GO(ld_go), .LD_L1_HIT(l1), .LD_PENDING(pnd), .LD_L2_HIT(l2),
      .LD_L3_HIT(l3), .LD_SNOOP(snp), .LD_MISS_FWD(fwd), .LD_MISS_MEM(mem), .LD_LOCAL_HOME(loc),
      .LD_EXCLUSIVE(excl), .LD_IO(io), .LD_UNCACHED(unc), .LAT_VALID(lat_valid), .LAT_VALUE(lat_value),
      .LAT_SOURCE(lat_source), .OC_VALID(oc_valid), .OC_REQ(oc_req), .OC_RESP(oc_resp), .OC_COUNT(oc_count));
   pipe_uncore_model pm_u (.clk(clk), .dispatch(ld_dispatch), .go(ld_go), .l1_hit(l1), .pending(pnd),
      .l2_hit(l2), .l3_hit(l3), .snoop(snp), .miss_fwd(fwd), .miss_mem(mem), .local_home(loc),
      .exclusive(excl), .io(io), .uncached(unc), .oc_valid(oc_valid), .oc_req(oc_req), .oc_resp(oc_resp));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic wr(input logic [MSR_ADDR_W-1:0] a, input logic [REG_W-1:0] d);
      @(posedge clk);
      #1 msr_wr = 1'b1;
      msr_addr = a;
      msr_wdata = d;
      @(posedge clk);
      #1 msr_wr = 1'b0;
   endtask : wr
   // answer is registered at the strobe's edge, so it is looked at 1 ns after it
   task automatic rd_chk(input logic [MSR_ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
      @(posedge clk);
      #1 msr_rd = 1'b1;
      msr_addr = a;
      @(posedge clk);
      #1 msr_rd = 1'b0;
      chk_bit(msr_rvalid, 1'b1);
      chk(msr_rdata, exp);
   endtask : rd_chk
   task automatic load_chk(input int lat, input logic [11:0] d, input logic v, input logic [15:0] val,
                           input logic [7:0] src);
      pm_u.issue_load(lat, d);
      chk_bit(lat_valid, v);
      chk(lat_value, val);
      chk({8'h00, lat_source}, {8'h00, src});
   endtask : load_chk
   task automatic test_regs;
      rd_chk(OFFCORE_SELECT_ADDR, OFFCORE_SELECT_RESET);
      rd_chk(LATENCY_THRESHOLD_ADDR, LATENCY_THRESHOLD_RESET);
      wr(12'h123, 16'hFFFF);
      rd_chk(12'h123, 16'h0000);
      wr(OFFCORE_SELECT_ADDR, 16'hFFFF);
      rd_chk(OFFCORE_SELECT_ADDR, 16'hF7FF);
      rd_chk(LATENCY_THRESHOLD_ADDR, 16'h0003);
      $display("test regs done");
   endtask : test_regs
   task automatic test_codes;
      // each row: descriptor, expected code; latency 6 stays above the reset threshold of 3
      logic [11:0] d [16] = '{12'h000, 12'h200, 12'h100, 12'h080, 12'h040, 12'h050, 12'h060, 12'h00A,
                             12'h008, 12'h006, 12'h007, 12'h004, 12'h005, 12'h400, 12'hC00, 12'h600};
      logic [7:0] c [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08,
                            8'h00, 8'h0A, 8'h0C, 8'h0B, 8'h0D, 8'h0F, 8'h0F, 8'h0E};
      c[13] = 8'h0E;
      for (int i = 0; i < 16; i++)
         load_chk(6, d[i], 1'b1, 16'h0006, c[i]);
      $display("test codes done");
   endtask : test_codes
   task automatic test_threshold;
      wr(LATENCY_THRESHOLD_ADDR, 16'h000A);
      load_chk(10, 12'h080, 1'b0, 16'h0006, 8'h0E);
      load_chk(11, 12'h080, 1'b1, 16'h000B, 8'h03);
      wr(LATENCY_THRESHOLD_ADDR, 16'h0003);
      load_chk(2, 12'h200, 1'b1, 16'h0004, 8'h01);
      wr(LATENCY_THRESHOLD_ADDR, 16'h0004);
      load_chk(4, 12'h100, 1'b0, 16'h0004, 8'h01);
      load_chk(5, 12'h100, 1'b1, 16'h0005, 8'h02);
      rd_chk(LATENCY_THRESHOLD_ADDR, 16'h0004);
      $display("test threshold done");
   endtask : test_threshold
   task automatic test_offcore;
      logic [7:0] b;
      for (int k = 0; k < 8; k++)
      begin
         b = 8'h01 << k;
         wr(OFFCORE_SELECT_ADDR, {b, b});
         pm_u.send_oc(b, b);
         chk_bit(oc_count, k != 3);
         pm_u.send_oc(~b, b);
         chk_bit(oc_count, 1'b0);
         pm_u.send_oc(b, ~b);
         chk_bit(oc_count, 1'b0);
      end
      // writeback paired with a usable response, since its own response bit is reserved
      wr(OFFCORE_SELECT_ADDR, 16'h0108);
      pm_u.send_oc(8'h08, 8'h01);
      chk_bit(oc_count, 1'b1);
      $display("test offcore done");
   endtask : test_offcore
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : finish_test
   initial
   begin
      rst = 1'b1;
      msr_wr = 1'b0;
      msr_rd = 1'b0;
      msr_addr = 12'h000;
      msr_wdata = 16'h0000;
      repeat (3) @(posedge clk);
      #1 rst = 1'b0;
      test_regs();
      test_codes();
      test_threshold();
      test_offcore();
      finish_test();
   end
   // whole run is about 260 cycles; the limit leaves ample margin
   initial
   begin
      #40000;
      fails++;
      $display("[FAIL] %0t watchdog expired", $time);
      finish_test();
   end
endmodule : tb_load_latency_offcore_qualifier
